// ==== rtl/foc_fault_pkg.sv ====
// Constants and carrier types for the FOC reference routing and fault supervisor
package foc_fault_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned LOCK_TIMEOUT_MS   = 100;
  localparam int unsigned LOCK_TIMEOUT_CYC  = LOCK_TIMEOUT_MS * CLK_MHZ * 1000;

  // ----------------------------------------------------------------
  // Thresholds, all supply figures in mV
  // ----------------------------------------------------------------
  localparam logic [15:0] UV_LEVEL_0        = 16'h7d00;
  localparam logic [15:0] UV_LEVEL_1        = 16'h61a8;
  localparam logic [15:0] UV_LEVEL_2        = 16'h1b58;
  localparam logic [15:0] UV_HYST_MV        = 16'h03e8;
  localparam logic [7:0]  OT_HYST_C         = 8'h0f;
  localparam logic [11:0] VDS_LEVEL_0       = 12'h1f4;
  localparam logic [11:0] VDS_LEVEL_1       = 12'h2ee;
  localparam logic [11:0] VDS_LEVEL_2       = 12'h3e8;
  localparam logic [11:0] VDS_LEVEL_3       = 12'h5dc;

  // ----------------------------------------------------------------
  // Datapath scaling
  // ----------------------------------------------------------------
  localparam logic [11:0] DUTY_FULL         = 12'hfff;
  localparam logic [7:0]  PCT_SCALE         = 8'h64;
  localparam int unsigned PI_SHIFT          = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_STANDBY, ST_WINDMILL, ST_RUN, ST_FAIL} ctrl_state_t;

  typedef struct packed {
    logic        speed_mode;
    logic [15:0] d_axis_current_ref;
    logic [7:0]  speed_prop_gain;
    logic [7:0]  speed_int_gain;
    logic [7:0]  d_current_prop_gain;
    logic [7:0]  d_current_int_gain;
    logic [7:0]  q_current_prop_gain;
    logic [7:0]  q_current_int_gain;
    logic [15:0] nominal_supply_setting;
    logic [1:0]  undervoltage_threshold;
    logic [15:0] overvoltage_threshold;
    logic [1:0]  drain_voltage_trip_level;
    logic [7:0]  shutdown_temp;
    logic [15:0] command_on_threshold;
    logic [15:0] command_off_threshold;
    logic        undervoltage_mask;
    logic        overtemp_mask;
    logic        overvoltage_fault_en;
    logic        overcurrent_fault_en;
    logic        stall_fault_en;
    logic        no_motor_fault_en;
  } nvm_cfg_t;

  typedef struct packed {
    logic uv;
    logic ot;
    logic ov;
    logic oc;
    logic stall;
  } fault_flags_t;

  typedef struct packed {
    nvm_cfg_t          cfg;
    logic              loaded;
    ctrl_state_t       state;
    fault_flags_t      flags;
    logic              oc_off_seen;
    logic [31:0]       lock_cnt;
    logic [31:0]       spd_int;
    logic [1:0][31:0]  cur_int;
    logic              brk_s1;
    logic              brk_s2;
    logic              lgc_s1;
    logic              lgc_s2;
    logic              fault_n;
    logic              out_en;
    logic              brake;
    logic              start_moving;
    logic              nvm_wr_ok;
    logic [15:0]       iq_ref;
    logic [15:0]       id_ref;
    logic [1:0][15:0]  v_dq;
    logic [2:0][11:0]  duty;
  } sup_state_t;

endpackage

// ==== rtl/foc_fault_supervisor.sv ====
// FOC reference routing, supply-compensated duty and fault supervisor
// Behaviour
// RULE1: Speed mode: command is speed-loop setpoint, its output is Q current reference.
// RULE2: Torque mode: command goes straight to Q current reference.
// RULE3: D current reference comes from a configuration setting.
// RULE4: Separate speed and current PI loops, gains from stored configuration.
// RULE5: Duty equals phase voltage over supply percentage times nominal supply.
// RULE6: Any enabled fault drives the active-low fault output low.
// RULE7: No braking in supply, thermal or stall faults; only overcurrent may brake.
// RULE8: Each fault individually maskable; masked faults neither disable nor report.
// RULE9: One status flag per fault, readable by the host.
// RULE10: Overcurrent latches outputs off until command off-then-on or power cycle.
// RULE11: Stall or no-motor disables outputs, starts lock timeout, holds latched flag.
// RULE12: Supply or thermal fault disables outputs, enters fail, reports flag.
// RULE13: Supply and thermal faults self-clear and return to standby.
// RULE14: From standby, command above on-threshold enters windmill speed check.
// RULE15: Undervoltage clears only above threshold plus hysteresis.
// RULE16: Undervoltage codes 0,1,2 select 32 V, 25 V and 7 V.
// RULE17: Overtemperature clears only below shutdown minus hysteresis.
// RULE18: Overvoltage clears once supply falls below programmable threshold.
// RULE19: Supply, thermal and overcurrent checks run in every mode and state.
// RULE20: In undervoltage with logic supply valid, stored configuration may be rewritten.
// RULE21: New configuration values act only after the next power-on reset.
// RULE22: Host should talk only in standby with motor stopped, outside undervoltage.
// RULE23: Overcurrent when a conducting transistor's drain voltage exceeds selected level.
// RULE24: With several faults, outputs stay off until every fault has cleared.
`timescale 1ns/1ps
`default_nettype none

module foc_fault_supervisor #(
  parameter int unsigned LOCK_CYC = foc_fault_pkg::LOCK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  // Stored configuration, sampled once after reset
  input  wire foc_fault_pkg::nvm_cfg_t      nvm_cfg,
  input  wire logic                         user_mode,
  // Control inputs
  input  wire logic signed [15:0]           motor_command,
  input  wire logic signed [15:0]           speed_est,
  input  wire logic signed [15:0]           d_current_meas,
  input  wire logic signed [15:0]           q_current_meas,
  input  wire logic [2:0][15:0]             phase_voltage_mv,
  input  wire logic                         rotor_moving,
  // Measurements and events
  input  wire logic [15:0]                  supply_mv,
  input  wire logic [7:0]                   junction_temp,
  input  wire logic [5:0][11:0]             drain_voltage_mv,
  input  wire logic [5:0]                   fet_conducting,
  input  wire logic                         stall_event,
  input  wire logic                         no_motor_event,
  input  wire logic                         stall_present,
  // Pins
  input  wire logic                         brake_in_n,
  input  wire logic                         logic_supply_ok,
  output logic                              fault_out_n,
  // Control outputs
  output logic                              outputs_enable,
  output logic                              brake_active,
  output logic                              start_moving,
  output logic                              nvm_write_allow,
  output foc_fault_pkg::ctrl_state_t        ctrl_state,
  output foc_fault_pkg::fault_flags_t       fault_status,
  output logic [15:0]                       q_axis_current_ref,
  output logic [15:0]                       d_axis_current_ref,
  output logic [1:0][15:0]                  v_dq,
  output logic [2:0][11:0]                  duty
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      return 16'h7fff;
    end else if (v < -32'sd32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  foc_fault_pkg::sup_state_t st_r;
  foc_fault_pkg::sup_state_t st_nxt;

  logic [15:0]        uv_level;
  logic [11:0]        vds_level;
  logic [5:0]         vds_trip;
  logic [31:0]        supply_pct;
  logic signed [31:0] spd_err;
  logic signed [31:0] spd_int_nxt;
  logic [15:0]        spd_out;
  logic [1:0][31:0]   cur_int_nxt;
  logic [1:0][15:0]   v_calc;
  logic [2:0][11:0]   duty_calc;

  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  // RULE16 undervoltage level decode
  always_comb begin
    unique case (st_r.cfg.undervoltage_threshold)
      2'h0:    uv_level = foc_fault_pkg::UV_LEVEL_0;
      2'h1:    uv_level = foc_fault_pkg::UV_LEVEL_1;
      default: uv_level = foc_fault_pkg::UV_LEVEL_2;
    endcase
  end

  // RULE23 drain voltage level decode
  always_comb begin
    unique case (st_r.cfg.drain_voltage_trip_level)
      2'h0: vds_level = foc_fault_pkg::VDS_LEVEL_0;
      2'h1: vds_level = foc_fault_pkg::VDS_LEVEL_1;
      2'h2: vds_level = foc_fault_pkg::VDS_LEVEL_2;
      2'h3: vds_level = foc_fault_pkg::VDS_LEVEL_3;
    endcase
  end

  // ----------------------------------------------------------------
  // Control loops and duty
  // ----------------------------------------------------------------
  // RULE4 speed PI
  assign spd_err     = 32'(motor_command) - 32'(speed_est);
  assign spd_int_nxt = signed'(st_r.spd_int)
                       + spd_err * signed'(32'(st_r.cfg.speed_int_gain));
  assign spd_out     = sat16((spd_err * signed'(32'(st_r.cfg.speed_prop_gain))
                              + spd_int_nxt) >>> foc_fault_pkg::PI_SHIFT);

  // Supply as a percentage of nominal, zero nominal gives zero percent
  assign supply_pct = (st_r.cfg.nominal_supply_setting == 16'h0000) ? 32'h0000_0000 :
                      (32'(supply_mv) * 32'(foc_fault_pkg::PCT_SCALE))
                      / 32'(st_r.cfg.nominal_supply_setting);

  for (genvar a = 0; a < 2; a++) begin : g_cur
    logic signed [31:0] err;
    logic signed [31:0] kp;
    logic signed [31:0] ki;
    // RULE4 current PI per axis
    assign kp  = signed'(32'(a == 0 ? st_r.cfg.d_current_prop_gain
                                    : st_r.cfg.q_current_prop_gain));
    assign ki  = signed'(32'(a == 0 ? st_r.cfg.d_current_int_gain
                                    : st_r.cfg.q_current_int_gain));
    assign err = (a == 0) ? 32'(signed'(st_r.id_ref)) - 32'(d_current_meas)
                          : 32'(signed'(st_r.iq_ref)) - 32'(q_current_meas);
    assign cur_int_nxt[a] = 32'(signed'(st_r.cur_int[a]) + err * ki);
    assign v_calc[a] = sat16((err * kp + signed'(cur_int_nxt[a]))
                             >>> foc_fault_pkg::PI_SHIFT);
  end

  for (genvar p = 0; p < 3; p++) begin : g_duty
    logic [39:0] num;
    logic [39:0] den;
    logic [39:0] quo;
    // RULE5 supply-compensated duty
    assign num = 40'(phase_voltage_mv[p]) * 40'(foc_fault_pkg::PCT_SCALE)
                 * 40'(foc_fault_pkg::DUTY_FULL);
    assign den = 40'(supply_pct) * 40'(st_r.cfg.nominal_supply_setting);
    assign quo = (den == 40'h0) ? 40'(foc_fault_pkg::DUTY_FULL) : num / den;
    assign duty_calc[p] = (quo > 40'(foc_fault_pkg::DUTY_FULL))
                          ? foc_fault_pkg::DUTY_FULL : quo[11:0];
  end

  for (genvar f = 0; f < 6; f++) begin : g_vds
    // RULE23 only a conducting transistor can trip
    assign vds_trip[f] = fet_conducting[f] & (drain_voltage_mv[f] > vds_level);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic any_fault;
    logic cmd_off;
    logic cmd_on;
    logic stall_hit;
    any_fault = 1'b0;
    cmd_off   = 1'b0;
    cmd_on    = 1'b0;
    stall_hit = 1'b0;
    st_nxt    = st_r;

    st_nxt.brk_s1 = brake_in_n;
    st_nxt.brk_s2 = st_r.brk_s1;
    st_nxt.lgc_s1 = logic_supply_ok;
    st_nxt.lgc_s2 = st_r.lgc_s1;

    if (!st_r.loaded) begin
      // RULE21 configuration captured once after reset only
      st_nxt.cfg    = nvm_cfg;
      st_nxt.loaded = 1'b1;
    end else begin
      cmd_off = motor_command < signed'(st_r.cfg.command_off_threshold);
      cmd_on  = motor_command > signed'(st_r.cfg.command_on_threshold);

      // RULE19 diagnostics ignore state and mode
      // RULE15 undervoltage hysteresis, RULE8 mask
      st_nxt.flags.uv = !st_r.cfg.undervoltage_mask &&
                        (st_r.flags.uv ? supply_mv <= uv_level + foc_fault_pkg::UV_HYST_MV
                                       : supply_mv < uv_level);
      // RULE17 thermal hysteresis
      st_nxt.flags.ot = !st_r.cfg.overtemp_mask &&
                        (st_r.flags.ot
                         ? junction_temp >= st_r.cfg.shutdown_temp - foc_fault_pkg::OT_HYST_C
                         : junction_temp > st_r.cfg.shutdown_temp);
      // RULE18 overvoltage clears below threshold
      st_nxt.flags.ov = st_r.cfg.overvoltage_fault_en &&
                        (st_r.flags.ov ? supply_mv >= st_r.cfg.overvoltage_threshold
                                       : supply_mv > st_r.cfg.overvoltage_threshold);

      // RULE10 overcurrent latch, off then on clears, a new trip wins
      if (st_r.cfg.overcurrent_fault_en && |vds_trip) begin
        st_nxt.flags.oc    = 1'b1;
        st_nxt.oc_off_seen = 1'b0;
      end else if (st_r.flags.oc) begin
        if (cmd_off) begin
          st_nxt.oc_off_seen = 1'b1;
        end else if (st_r.oc_off_seen && cmd_on) begin
          st_nxt.flags.oc    = 1'b0;
          st_nxt.oc_off_seen = 1'b0;
        end
      end
      if (!st_r.cfg.overcurrent_fault_en) begin
        st_nxt.flags.oc = 1'b0;
      end

      // RULE11 stall latch with lock timeout, a new event wins over a clear
      stall_hit = (stall_event && st_r.cfg.stall_fault_en)
               || (no_motor_event && st_r.cfg.no_motor_fault_en);
      if (stall_hit) begin
        st_nxt.flags.stall = 1'b1;
        st_nxt.lock_cnt    = 32'(LOCK_CYC);
      end else if (st_r.flags.stall) begin
        if (st_r.lock_cnt != 32'h0) begin
          st_nxt.lock_cnt = st_r.lock_cnt - 32'h1;
        end else if (!stall_present || cmd_off) begin
          st_nxt.flags.stall = 1'b0;
        end else begin
          st_nxt.lock_cnt = 32'(LOCK_CYC);
        end
      end

      any_fault = |st_nxt.flags;

      // RULE12 fail on any fault; RULE13 back to standby; RULE14 windmill check
      unique case (st_r.state)
        foc_fault_pkg::ST_STANDBY:
          if (any_fault) begin
            st_nxt.state = foc_fault_pkg::ST_FAIL;
          end else if (cmd_on) begin
            st_nxt.state = foc_fault_pkg::ST_WINDMILL;
          end
        foc_fault_pkg::ST_WINDMILL: begin
          st_nxt.start_moving = rotor_moving;
          st_nxt.state = any_fault ? foc_fault_pkg::ST_FAIL : foc_fault_pkg::ST_RUN;
        end
        foc_fault_pkg::ST_RUN:
          if (any_fault) begin
            st_nxt.state = foc_fault_pkg::ST_FAIL;
          end else if (cmd_off) begin
            st_nxt.state = foc_fault_pkg::ST_STANDBY;
          end
        foc_fault_pkg::ST_FAIL:
          // RULE24 leave only once every fault is gone
          if (!any_fault) begin
            st_nxt.state = foc_fault_pkg::ST_STANDBY;
          end
      endcase
    end

    any_fault = |st_nxt.flags;
    // RULE6 fault pin and output gating
    st_nxt.fault_n = !any_fault;
    st_nxt.out_en  = !any_fault;
    // RULE7 brake pin honoured only without supply, thermal or stall faults
    st_nxt.brake = !st_r.brk_s2 && !(st_nxt.flags.uv || st_nxt.flags.ot
                                     || st_nxt.flags.ov || st_nxt.flags.stall);
    // RULE20 reprogramming window during undervoltage
    st_nxt.nvm_wr_ok = st_nxt.flags.uv && st_r.lgc_s2 && user_mode;

    // RULE3 D reference from setting
    st_nxt.id_ref = st_r.cfg.d_axis_current_ref;
    if (st_r.state == foc_fault_pkg::ST_RUN && st_r.loaded) begin
      st_nxt.spd_int = 32'(spd_int_nxt);
      st_nxt.cur_int = cur_int_nxt;
      st_nxt.v_dq    = v_calc;
      // RULE1 speed mode; RULE2 torque mode bypass
      st_nxt.iq_ref  = st_r.cfg.speed_mode ? spd_out : 16'(motor_command);
    end else begin
      st_nxt.spd_int = 32'h0;
      st_nxt.cur_int = '0;
      st_nxt.v_dq    = '0;
      st_nxt.iq_ref  = st_r.cfg.speed_mode ? 16'h0000 : 16'(motor_command);
    end
    // Duty forced to zero while the bridge is disabled
    st_nxt.duty = st_nxt.out_en ? duty_calc : '0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r         <= '0;
      st_r.state   <= foc_fault_pkg::ST_STANDBY;
      st_r.brk_s1  <= 1'b1;
      st_r.brk_s2  <= 1'b1;
      st_r.fault_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RULE9 flags visible to the host
  assign fault_status       = st_r.flags;
  assign fault_out_n        = st_r.fault_n;
  assign outputs_enable     = st_r.out_en;
  assign brake_active       = st_r.brake;
  assign start_moving       = st_r.start_moving;
  assign nvm_write_allow    = st_r.nvm_wr_ok;
  assign ctrl_state         = st_r.state;
  assign q_axis_current_ref = st_r.iq_ref;
  assign d_axis_current_ref = st_r.id_ref;
  assign v_dq               = st_r.v_dq;
  assign duty               = st_r.duty;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_torque_bypass: assert property ( // RULE2
    st_r.loaded && !st_r.cfg.speed_mode |=> q_axis_current_ref == $past(motor_command))
    else $error("torque mode Q reference differs from command");

  a_speed_idle_ref: assert property ( // RULE1
    st_r.loaded && st_r.cfg.speed_mode && st_r.state != foc_fault_pkg::ST_RUN
    |=> q_axis_current_ref == 16'h0000)
    else $error("speed loop output present outside run");

  a_d_ref_setting: assert property ( // RULE3
    st_r.loaded |=> d_axis_current_ref == $past(st_r.cfg.d_axis_current_ref))
    else $error("D reference not from setting");

  a_no_brake_fault: assert property ( // RULE7
    fault_status.uv || fault_status.ot || fault_status.ov || fault_status.stall
    |-> !brake_active)
    else $error("brake active during non-overcurrent fault");

  a_fault_pin_low: assert property ( // RULE6
    |fault_status |-> !fault_out_n && !outputs_enable && duty == '0)
    else $error("fault present but pin high or outputs on");

  a_oc_latch_hold: assert property ( // RULE10
    fault_status.oc && !st_r.oc_off_seen |=> fault_status.oc)
    else $error("overcurrent latch cleared without off command");

  a_uv_masked: assert property ( // RULE8
    st_r.loaded && st_r.cfg.undervoltage_mask |=> !fault_status.uv)
    else $error("masked undervoltage reported");

  a_uv_hysteresis: assert property ( // RULE15
    st_r.loaded && fault_status.uv && supply_mv <= uv_level + foc_fault_pkg::UV_HYST_MV
    |=> fault_status.uv)
    else $error("undervoltage cleared inside hysteresis");

  a_ov_recover: assert property ( // RULE18
    st_r.loaded && fault_status.ov && supply_mv < st_r.cfg.overvoltage_threshold
    |=> !fault_status.ov)
    else $error("overvoltage not cleared below threshold");

  a_fail_to_standby: assert property ( // RULE13
    ctrl_state == foc_fault_pkg::ST_FAIL && !(|st_nxt.flags)
    |=> ctrl_state == foc_fault_pkg::ST_STANDBY && fault_out_n)
    else $error("fail state not left after recovery");

  a_cfg_frozen: assert property ( // RULE21
    st_r.loaded |=> $stable(st_r.cfg))
    else $error("configuration changed after load");

  a_stall_timeout: assert property ( // RULE11
    fault_status.stall && st_r.lock_cnt != 32'h0 |=> fault_status.stall)
    else $error("stall flag cleared before lock timeout");

endmodule

`default_nettype wire

// ==== tb/bridge_model.sv ====
// Inverter bridge model that drives drain-source voltages
`timescale 1ns/1ps
`default_nettype none

module bridge_model (
  // Short request from the bench
  input  wire logic         short_on,
  // Bridge sense lines
  output logic [5:0]        fet_conducting,
  output logic [5:0][11:0]  drain_voltage_mv
);
  // ----------------------------------------------------------------
  // Bridge
  // ----------------------------------------------------------------
  // Off transistors see link voltage, so only conducting ones may trip
  always_comb begin
    fet_conducting = 6'h21;
    for (int i = 0; i < 6; i++) begin
      drain_voltage_mv[i] = fet_conducting[i] ? (short_on ? 12'h258 : 12'h064) : 12'hbb8;
    end
  end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the FOC fault supervisor
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                         clock, sys_rst, user_mode, lgc_ok, stall_event;
  logic                         stall_present, short_on, fault_out_n, outputs_enable;
  logic                         brake_active, no_motor_event;
  logic [1:0][15:0]             v_dq_out;
  foc_fault_pkg::nvm_cfg_t      nvm_cfg;
  logic signed [15:0]           motor_command;
  logic [2:0][15:0]             phase_voltage_mv;
  logic [15:0]                  supply_mv, q_ref, d_ref;
  logic [7:0]                   junction_temp;
  logic [5:0]                   fet_conducting;
  logic [5:0][11:0]             drain_voltage_mv;
  foc_fault_pkg::ctrl_state_t   ctrl_state;
  foc_fault_pkg::fault_flags_t  st;
  logic [2:0][11:0]             duty;
  logic                         nvm_write_allow;
  int                           n_errors, checks_done;

  bridge_model bridge_model_inst (.short_on(short_on), .fet_conducting(fet_conducting),
    .drain_voltage_mv(drain_voltage_mv));

  // Fault pin looped onto the brake pin
  foc_fault_supervisor #(.LOCK_CYC(20)) foc_fault_supervisor_inst (.clock(clock),
    .sys_rst(sys_rst), .nvm_cfg(nvm_cfg), .user_mode(user_mode),
    .motor_command(motor_command), .speed_est(16'sh0000), .d_current_meas(16'sh0000),
    .q_current_meas(16'sh0000), .phase_voltage_mv(phase_voltage_mv), .rotor_moving(1'b0),
    .supply_mv(supply_mv), .junction_temp(junction_temp),
    .drain_voltage_mv(drain_voltage_mv), .fet_conducting(fet_conducting),
    .stall_event(stall_event), .no_motor_event(no_motor_event),
    .stall_present(stall_present),
    .brake_in_n(fault_out_n), .logic_supply_ok(lgc_ok), .fault_out_n(fault_out_n),
    .outputs_enable(outputs_enable), .brake_active(brake_active), .start_moving(),
    .nvm_write_allow(nvm_write_allow), .ctrl_state(ctrl_state), .fault_status(st),
    .q_axis_current_ref(q_ref), .d_axis_current_ref(d_ref), .v_dq(v_dq_out), .duty(duty));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_start_duty;
    @(posedge clock); motor_command <= 16'sh0200; tick(1);
    chk(q_ref, 16'h0200); // torque path
    chk(d_ref, 16'h0011); // d reference
    chk(ctrl_state, foc_fault_pkg::ST_WINDMILL); // windmill entry
    tick(2);
    chk(duty[0], 12'h7ff); // full supply
    @(posedge clock); supply_mv <= 16'h5dc0; tick(2);
    chk(duty[2], 12'hfff); // half supply
    @(posedge clock); supply_mv <= 16'hbb80; tick(1);
  endtask

  task automatic t_uv;
    @(posedge clock); supply_mv <= 16'h1000; tick(1);
    chk({st.uv, fault_out_n, outputs_enable}, 3'h4); // uv trip
    chk(ctrl_state, foc_fault_pkg::ST_FAIL); // fail state
    tick(4);
    chk(brake_active, 1'b0); // no brake in uv
    chk(nvm_write_allow, 1'b1); // rewrite window
    @(posedge clock); supply_mv <= 16'h1c00; tick(2);
    chk(st.uv, 1'b1); // inside hysteresis
    @(posedge clock); supply_mv <= 16'h2000; tick(1);
    chk({st.uv, fault_out_n}, 2'h1); // self clear
    chk(ctrl_state, foc_fault_pkg::ST_STANDBY); // back to standby
    chk(nvm_write_allow, 1'b0); // closed once supply is back
  endtask

  task automatic t_ot_ov;
    @(posedge clock); nvm_cfg.overvoltage_fault_en <= 1'b0; junction_temp <= 8'ha0;
    supply_mv <= 16'he000; tick(1);
    chk({st.ot, st.ov}, 2'h3); // late mask ignored
    @(posedge clock); junction_temp <= 8'h8a; supply_mv <= 16'hdac0; tick(2);
    chk({st.ot, st.ov}, 2'h3); // inside hysteresis
    @(posedge clock); supply_mv <= 16'hd000; tick(2);
    chk({st.ov, fault_out_n, outputs_enable}, 3'h0); // ot still holds
    @(posedge clock); junction_temp <= 8'h80; tick(2);
    chk({st.ot, fault_out_n}, 2'h1); // both cleared
  endtask

  task automatic t_oc;
    @(posedge clock); short_on <= 1'b1; tick(1);
    chk({st.oc, fault_out_n, outputs_enable}, 3'h4); // conducting trip
    tick(4);
    chk(brake_active, 1'b1); // brake on overcurrent
    @(posedge clock); short_on <= 1'b0; tick(3);
    chk(st.oc, 1'b1); // latched
    @(posedge clock); motor_command <= 16'sh0000; tick(1);
    @(posedge clock); motor_command <= 16'sh0200; tick(2);
    chk({st.oc, fault_out_n}, 2'h1); // off-on clears
  endtask

  task automatic t_stall;
    @(posedge clock); stall_present <= 1'b1; stall_event <= 1'b1;
    @(posedge clock); stall_event <= 1'b0; tick(1);
    chk({st.stall, outputs_enable, fault_out_n}, 3'h4); // stall trip
    tick(30);
    chk(st.stall, 1'b1); // held while present
    @(posedge clock); stall_present <= 1'b0; tick(25);
    chk(st.stall, 1'b0); // timeout clears
    @(posedge clock); no_motor_event <= 1'b1; motor_command <= 16'sh0000;
    @(posedge clock); no_motor_event <= 1'b0; tick(1);
    chk(st.stall, 1'b1); // no-motor start
  endtask

  task automatic t_mask;
    tick(24);
    chk(ctrl_state, foc_fault_pkg::ST_STANDBY); // host writes only in standby
    @(posedge clock); nvm_cfg.undervoltage_mask <= 1'b1; sys_rst <= 1'b1;
    nvm_cfg.speed_mode <= 1'b1;
    @(posedge clock); sys_rst <= 1'b0; tick(2);
    @(posedge clock); supply_mv <= 16'h1000; motor_command <= 16'sh00c0; tick(2);
    chk({st.uv, fault_out_n, outputs_enable}, 3'h3); // masked uv
    chk(q_ref, 16'h0000); // speed loop idle outside run
    @(posedge clock); motor_command <= 16'sh0200; tick(3);
    chk(q_ref, 16'h0002); // speed loop output as Q reference
    chk(v_dq_out[0], 16'h0002); // D current loop proportional path
  endtask

  initial begin
    #200us;
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    checks_done = 0;
    nvm_cfg = '0;
    nvm_cfg.d_axis_current_ref = 16'h0011;
    nvm_cfg.speed_prop_gain = 8'h01;
    nvm_cfg.d_current_prop_gain = 8'h20;
    nvm_cfg.nominal_supply_setting = 16'hbb80;
    nvm_cfg.undervoltage_threshold = 2'h2;
    nvm_cfg.overvoltage_threshold = 16'hdac0;
    nvm_cfg.shutdown_temp = 8'h96;
    nvm_cfg.command_on_threshold = 16'h0100;
    nvm_cfg.command_off_threshold = 16'h0080;
    {nvm_cfg.overvoltage_fault_en, nvm_cfg.overcurrent_fault_en} = 2'h3;
    {nvm_cfg.stall_fault_en, nvm_cfg.no_motor_fault_en} = 2'h3;
    {user_mode, lgc_ok, stall_event, stall_present, short_on, no_motor_event} = 6'h30;
    motor_command = 16'sh0000;
    phase_voltage_mv = {3{16'h5dc0}};
    supply_mv = 16'hbb80;
    junction_temp = 8'h32;
    sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    tick(2);
    t_start_duty();
    t_uv();
    t_ot_ov();
    t_oc();
    t_stall();
    t_mask();
    complete_run();
  end
endmodule

`default_nettype wire
